// ===== ecl_map.svh
// Register indices, field positions, reset values and timing constants
// of the configuration loader.
// Assumes the includer wants plain macros; it defines nothing else.
`ifndef ECL_MAP_SVH
`define ECL_MAP_SVH

// Port register indices; APB byte address is four times the index.
`define ECL_IDX_IO_BASE   9'h020
`define ECL_IDX_INT_NUM   9'h022
`define ECL_IDX_RX_CFG    9'h102
`define ECL_IDX_RX_CTL    9'h104
`define ECL_IDX_TX_CFG    9'h106
`define ECL_IDX_TX_CMD    9'h108
`define ECL_IDX_BUF_CFG   9'h10A
`define ECL_IDX_RSVD_A    9'h10C
`define ECL_IDX_RSVD_B    9'h10E
`define ECL_IDX_RSVD_C    9'h110
`define ECL_IDX_LINE_CTL  9'h112
`define ECL_IDX_SELF_CTL  9'h114
`define ECL_IDX_BUS_CTL   9'h116
`define ECL_IDX_TEST_CTL  9'h118

// Loader status and interrupt register indices.
`define ECL_IDX_STATUS    10'h200
`define ECL_IDX_IRQ_STAT  10'h201
`define ECL_IDX_IRQ_MASK  10'h202

// Default register contents; reserved words come up as zero.
`define ECL_DEF_IO_BASE   16'h0300
`define ECL_DEF_INT_NUM   16'h0004
`define ECL_DEF_RX_CFG    16'h0003
`define ECL_DEF_RX_CTL    16'h0005
`define ECL_DEF_TX_CFG    16'h0007
`define ECL_DEF_TX_CMD    16'h0009
`define ECL_DEF_BUF_CFG   16'h000B
`define ECL_DEF_RSVD      16'h0000
`define ECL_DEF_LINE_CTL  16'h0013
`define ECL_DEF_SELF_CTL  16'h0015
`define ECL_DEF_BUS_CTL   16'h0017
`define ECL_DEF_TEST_CTL  16'h0019

// Field positions.
`define ECL_CTL_RESET     6
`define ECL_CTL_SUSPEND   8
`define ECL_ST_NONSEQ     0
`define ECL_ST_BIG        1
`define ECL_ST_INIT       7
`define ECL_ST_BUSY       8
`define ECL_ST_VALID      10
`define ECL_IRQ_LOADED    0
`define ECL_IRQ_FAILED    1
`define ECL_IRQ_NOMEM     2

// Block header signature in bits 15..13, end marker, read command.
`define ECL_HDR_SIG       3'h5
`define ECL_END_MARK      16'hFFFF
`define ECL_CMD_READ      3'h6
`define ECL_PROBE_BIT     5'h09

// Serial clock timing derived from the bus clock.
`define ECL_PCLK_HZ       250000000
`define ECL_SK_HZ         1000000
`define ECL_SK_HALF       (`ECL_PCLK_HZ / (2 * `ECL_SK_HZ))
`define ECL_SENSE_WAIT    4'h4

`endif

// ===== ecl_pkg.sv
// Types shared by the configuration loader modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ecl_pkg;

  // Loader sequencer states, one-hot.
  typedef enum logic [4:0]
  {
    st_sense   = 5'h01,
    st_issue   = 5'h02,
    st_wait    = 5'h04,
    st_idle    = 5'h08,
    st_suspend = 5'h10
  } ecl_state_t;

  // One word read request to the serial engine.
  typedef struct packed
  {
    logic       start;
    logic       probe;
    logic       big;
    logic [7:0] addr;
  } ecl_rd_req_t;

  // One register write from the loader.
  typedef struct packed
  {
    logic        en;
    logic [8:0]  addr;
    logic [15:0] data;
  } ecl_wr_t;

endpackage
`default_nettype wire

// ===== ecl_sync.sv
// Two-flop synchroniser for one level from outside the pclk domain.
// Assumes the input is a slow level; only the second flop is read.
`timescale 1ns/1ps
`default_nettype none
module ecl_sync
(
  // Clock and reset.
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in and out.
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  // The first flop only feeds the second one.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // ecl_sync
`default_nettype wire

// ===== ecl_serial.sv
// Serial engine: reads one 16-bit word from a three-wire EEPROM.
// Assumes din is already synchronised and pulled high when undriven.
`timescale 1ns/1ps
`default_nettype none
`include "ecl_map.svh"
module ecl_serial
(
  // Clock and reset.
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Request and answer.
  input  var  ecl_pkg::ecl_rd_req_t req,
  output logic                     done,
  output logic [15:0]              word,
  output logic                     big,
  // Memory pins.
  input  wire logic                din,
  output logic                     cs,
  output logic                     sck,
  output logic                     dout
);

  logic [6:0]  div_q;
  logic [10:0] cmd_q;
  logic [4:0]  bi_q;
  logic        probe_q;
  logic        tick;
  logic [4:0]  cmd_len;
  logic [4:0]  last;

  assign tick    = (div_q == 7'(`ECL_SK_HALF - 1));
  assign cmd_len = big ? 5'h0B : 5'h09;
  assign last    = cmd_len + 5'h10;

  // Half-period divider runs only while selected.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 7'h00;
    else if (!cs || tick)
      div_q <= 7'h00;
    else
      div_q <= div_q + 7'h01;
  end

  // Command out on the low phase, data sampled at the falling edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs <= 1'b0; sck <= 1'b0; dout <= 1'b0; done <= 1'b0;
      big <= 1'b0; probe_q <= 1'b0; bi_q <= 5'h00;
      cmd_q <= 11'h000; word <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (!cs)
      begin
        if (req.start)
        begin
          cs      <= 1'b1;
          sck     <= 1'b0;
          bi_q    <= 5'h00;
          big     <= req.big;
          probe_q <= req.probe;
          cmd_q   <= req.big ? {`ECL_CMD_READ, req.addr}
                             : {`ECL_CMD_READ, req.addr[5:0], 2'h0};
          dout    <= 1'b1;
        end
      end
      else if (tick)
      begin
        if (!sck)
          sck <= 1'b1;
        else
        begin
          sck <= 1'b0;
          // A large part still takes address bits at the tenth edge,
          // so its undriven output reads high instead of the dummy 0.
          if (probe_q && bi_q == `ECL_PROBE_BIT && din)
            big <= 1'b1;
          if (bi_q > cmd_len)
            word <= {word[14:0], din};
          if (bi_q == last)
          begin
            cs   <= 1'b0;
            dout <= 1'b0;
            done <= 1'b1;
          end
          else
          begin
            bi_q  <= bi_q + 5'h01;
            cmd_q <= {cmd_q[9:0], 1'b0};
            dout  <= ((bi_q + 5'h01) < cmd_len) ? cmd_q[9] : 1'b0;
          end
        end
      end
    end
  end

endmodule // ecl_serial
`default_nettype wire

// ===== ecl_loader.sv
// Reset-time configuration loader with APB register file.
// Assumes an APB master on pclk and a three-wire EEPROM on the pins.
//
// What this block does
// - Sense data-in pin after each restart.
// - High sense: load configuration from memory.
// - Low sense: no read, keep defaults.
// - Base address survives suspend entry and exit.
// - Supports 64 and 256 word parts.
// - Drives select, 1 MHz clock, data out.
// - User data beyond block, software only.
// - Header low byte is byte count.
// - Group header gives count and destination.
// - Word FFFFh means no more words.
// - Header fields: count-1, nine-bit address.
// - Accept only 101X header; LSB picks type.
// - Zero total sets valid, else defaults.
// - First read issues read of word zero.
`timescale 1ns/1ps
`default_nettype none
`include "ecl_map.svh"
module ecl_loader
(
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Configuration memory pins.
  input  wire logic        cfg_mem_serial_in,
  output logic             cfg_mem_select,
  output logic             cfg_mem_serial_clock,
  output logic             cfg_mem_serial_out,
  // Interrupt.
  output logic             irq
);

  localparam int NREG = 14;
  localparam logic [8:0] OFF [NREG] = '{
    `ECL_IDX_IO_BASE, `ECL_IDX_INT_NUM, `ECL_IDX_RX_CFG, `ECL_IDX_RX_CTL,
    `ECL_IDX_TX_CFG, `ECL_IDX_TX_CMD, `ECL_IDX_BUF_CFG, `ECL_IDX_RSVD_A,
    `ECL_IDX_RSVD_B, `ECL_IDX_RSVD_C, `ECL_IDX_LINE_CTL, `ECL_IDX_SELF_CTL,
    `ECL_IDX_BUS_CTL, `ECL_IDX_TEST_CTL};
  localparam logic [15:0] DEF [NREG] = '{
    `ECL_DEF_IO_BASE, `ECL_DEF_INT_NUM, `ECL_DEF_RX_CFG, `ECL_DEF_RX_CTL,
    `ECL_DEF_TX_CFG, `ECL_DEF_TX_CMD, `ECL_DEF_BUF_CFG, `ECL_DEF_RSVD,
    `ECL_DEF_RSVD, `ECL_DEF_RSVD, `ECL_DEF_LINE_CTL, `ECL_DEF_SELF_CTL,
    `ECL_DEF_BUS_CTL, `ECL_DEF_TEST_CTL};

  ecl_pkg::ecl_state_t  state_q;
  ecl_pkg::ecl_rd_req_t req;
  ecl_pkg::ecl_wr_t     ldr_wr_q;
  logic [15:0] reg_q [NREG];
  logic        din_s;
  logic        rd_done;
  logic [15:0] rd_word;
  logic        rd_big;
  logic [3:0]  settle_q;
  logic [7:0]  wa_q;
  logic [7:0]  rem_q;
  logic [7:0]  sum_q;
  logic [4:0]  grp_left_q;
  logic [8:0]  dest_q;
  logic        nonseq_q;
  logic        big_q;
  logic        init_done_flag_q;
  logic        cfg_mem_valid_flag_q;
  logic        restore_q;
  logic        keep_io_q;
  logic        restart_q;
  logic        suspend_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_mask_q;
  logic [2:0]  ev_d;
  logic        fin_ok_d;
  logic        fin_bad_d;
  logic        fin_none_d;
  logic [31:0] rd_mux;
  logic        hit;
  logic [9:0]  idx;
  logic        wr_acc;
  logic        setup;
  logic        self_wr;
  logic [7:0]  chk_total;

  // APB decoding; every register is one word, index = byte address / 4.
  assign idx    = paddr[11:2];
  assign setup  = psel && !penable;
  assign pready = psel && penable;
  assign wr_acc = psel && penable && pwrite;
  assign self_wr = wr_acc && !suspend_q && idx == {1'b0, `ECL_IDX_SELF_CTL};
  assign chk_total = sum_q + rd_word[15:8];

  // The input pin is foreign to pclk and crosses two flops first.
  ecl_sync u_sync
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (cfg_mem_serial_in),
    .sync_out (din_s)
  );

  ecl_serial u_serial
  (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (req),
    .done    (rd_done),
    .word    (rd_word),
    .big     (rd_big),
    .din     (din_s),
    .cs      (cfg_mem_select),
    .sck     (cfg_mem_serial_clock),
    .dout    (cfg_mem_serial_out)
  );

  // Read requests always carry a fresh address, so sequential and
  // non-sequential parts behave alike at the cost of command overhead.
  always_comb
  begin
    req.start = (state_q == ecl_pkg::st_issue);
    req.probe = (wa_q == 8'h00);
    req.big   = big_q && (wa_q != 8'h00);
    req.addr  = wa_q;
  end

  // Finish events decoded from the sensed pin or the word just received.
  always_comb
  begin
    fin_ok_d   = 1'b0;
    fin_bad_d  = 1'b0;
    fin_none_d = 1'b0;
    if (state_q == ecl_pkg::st_sense && settle_q == `ECL_SENSE_WAIT)
      fin_none_d = !din_s;
    else if (state_q == ecl_pkg::st_wait && rd_done)
    begin
      if (wa_q == 8'h00)
        fin_none_d = (rd_word[15:13] != `ECL_HDR_SIG);
      else if (rd_word == `ECL_END_MARK)
        fin_bad_d = 1'b1;
      else if (rem_q == 8'h00)
      begin
        fin_ok_d  = (chk_total == 8'h00);
        fin_bad_d = (chk_total != 8'h00);
      end
    end
  end

  // Sequencer: sense, header, groups, checksum.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ecl_pkg::st_sense;
      settle_q <= 4'h0; wa_q <= 8'h00; rem_q <= 8'h00; sum_q <= 8'h00;
      grp_left_q <= 5'h00; dest_q <= 9'h000; nonseq_q <= 1'b0;
      big_q <= 1'b0;
    end
    else if (restart_q)
    begin
      state_q  <= ecl_pkg::st_sense;
      settle_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        ecl_pkg::st_sense:
        begin
          settle_q <= settle_q + 4'h1;
          if (settle_q == `ECL_SENSE_WAIT)
          begin
            wa_q       <= 8'h00;
            grp_left_q <= 5'h00;
            state_q <= din_s ? ecl_pkg::st_issue : ecl_pkg::st_idle;
          end
        end
        ecl_pkg::st_issue:
          state_q <= ecl_pkg::st_wait;
        ecl_pkg::st_wait:
          if (rd_done)
          begin
            wa_q    <= wa_q + 8'h01;
            state_q <= ecl_pkg::st_issue;
            if (wa_q == 8'h00)
            begin
              big_q <= rd_big;
              nonseq_q <= rd_word[8];
              if (fin_none_d)
                state_q <= ecl_pkg::st_idle;
              rem_q <= rd_word[7:0];
              sum_q <= rd_word[15:8] + rd_word[7:0];
            end
            else if (fin_bad_d || fin_ok_d)
              state_q <= ecl_pkg::st_idle;
            else
            begin
              rem_q <= (rem_q < 8'h02) ? 8'h00 : rem_q - 8'h02;
              sum_q <= sum_q + rd_word[15:8] + rd_word[7:0];
              if (grp_left_q == 5'h00)
              begin
                grp_left_q <= {1'b0, rd_word[15:12]} + 5'h01;
                dest_q     <= rd_word[8:0];
              end
              else
              begin
                grp_left_q <= grp_left_q - 5'h01;
                dest_q     <= dest_q + 9'h002;
              end
            end
          end
        ecl_pkg::st_idle:
          if (suspend_q)
            state_q <= ecl_pkg::st_suspend;
        ecl_pkg::st_suspend:
          state_q <= ecl_pkg::st_suspend;
        default:
          state_q <= ecl_pkg::st_idle;
      endcase
    end
  end

  // Loader register writes, one cycle after the data word arrives.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ldr_wr_q <= '0;
    else
    begin
      ldr_wr_q.en   <= state_q == ecl_pkg::st_wait && rd_done &&
                       wa_q != 8'h00 && !fin_bad_d && !fin_ok_d &&
                       rem_q != 8'h00 && grp_left_q != 5'h00;
      ldr_wr_q.addr <= dest_q;
      ldr_wr_q.data <= rd_word;
    end
  end

  // Suspend, software reset and the restore pulse that goes with them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      suspend_q <= 1'b0; restart_q <= 1'b0;
      restore_q <= 1'b0; keep_io_q <= 1'b0;
    end
    else
    begin
      restart_q <= 1'b0;
      restore_q <= 1'b0;
      keep_io_q <= 1'b0;
      if (suspend_q && wr_acc)
      begin
        suspend_q <= 1'b0;
        restart_q <= 1'b1;
        restore_q <= 1'b1;
        keep_io_q <= 1'b1;
      end
      else if (self_wr && pwdata[`ECL_CTL_SUSPEND])
      begin
        suspend_q <= 1'b1;
        restore_q <= 1'b1;
        keep_io_q <= 1'b1;
      end
      else if (self_wr && pwdata[`ECL_CTL_RESET])
      begin
        restart_q <= 1'b1;
        restore_q <= 1'b1;
      end
      else if (fin_bad_d)
        restore_q <= 1'b1;
    end
  end

  // Port registers; the loader wins over a same-cycle bus write.
  generate
    for (genvar g = 0; g < NREG; g++)
    begin : g_reg
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          reg_q[g] <= DEF[g];
        else if (restore_q && !(g == 0 && keep_io_q))
          reg_q[g] <= DEF[g];
        else if (ldr_wr_q.en && ldr_wr_q.addr == OFF[g])
          reg_q[g] <= ldr_wr_q.data;
        else if (wr_acc && !suspend_q && idx == {1'b0, OFF[g]})
          reg_q[g] <= pwdata[15:0];
      end
    end
  endgenerate

  // Status flags; a restart clears both until the new pass ends.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      init_done_flag_q     <= 1'b0;
      cfg_mem_valid_flag_q <= 1'b0;
    end
    else if (restart_q)
    begin
      init_done_flag_q     <= 1'b0;
      cfg_mem_valid_flag_q <= 1'b0;
    end
    else
    begin
      if (fin_ok_d || fin_bad_d || fin_none_d)
        init_done_flag_q <= 1'b1;
      if (fin_ok_d)
        cfg_mem_valid_flag_q <= 1'b1;
      else if (fin_bad_d)
        cfg_mem_valid_flag_q <= 1'b0;
    end
  end

  // Sticky interrupt bits; an event in the clearing cycle still sets.
  assign ev_d = {fin_none_d, fin_bad_d, fin_ok_d};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      irq        <= 1'b0;
    end
    else
    begin
      if (wr_acc && idx == `ECL_IDX_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~pwdata[2:0]) | ev_d;
      else
        irq_stat_q <= irq_stat_q | ev_d;
      if (wr_acc && idx == `ECL_IDX_IRQ_MASK)
        irq_mask_q <= pwdata[2:0];
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Read mux for the setup cycle; unmapped indices answer with an error.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    hit    = 1'b0;
    for (int i = 0; i < NREG; i++)
      if (idx == {1'b0, OFF[i]})
      begin
        rd_mux = {16'h0000, reg_q[i]};
        hit    = 1'b1;
      end
    if (idx == `ECL_IDX_STATUS)
    begin
      hit = 1'b1;
      rd_mux[`ECL_ST_VALID]  = cfg_mem_valid_flag_q;
      rd_mux[`ECL_ST_INIT]   = init_done_flag_q;
      rd_mux[`ECL_ST_BUSY]   = !(state_q == ecl_pkg::st_idle ||
                                 state_q == ecl_pkg::st_suspend);
      rd_mux[`ECL_ST_NONSEQ] = nonseq_q;
      rd_mux[`ECL_ST_BIG]    = big_q;
    end
    if (idx == `ECL_IDX_IRQ_STAT)
    begin
      hit = 1'b1;
      rd_mux[2:0] = irq_stat_q;
    end
    if (idx == `ECL_IDX_IRQ_MASK)
    begin
      hit = 1'b1;
      rd_mux[2:0] = irq_mask_q;
    end
  end

  // Read data and error are captured in setup, shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= (hit && !pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= !hit;
    end
  end

endmodule // ecl_loader
`default_nettype wire

// ===== ecl_loader_checker.sv
// Concurrent checks on the loader's APB and memory pins.
// Assumes it is bound into ecl_loader and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ecl_loader_checker
(
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Memory pins and interrupt.
  input wire logic        cfg_mem_serial_in,
  input wire logic        cfg_mem_select,
  input wire logic        cfg_mem_serial_clock,
  input wire logic        cfg_mem_serial_out,
  input wire logic        irq
);
  logic [7:0] run_q;
  logic       sck_q;

  // Cycles since the serial clock last moved; wrapping while idle is fine.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 8'h00;
      sck_q <= 1'b0;
    end
    else
    begin
      sck_q <= cfg_mem_serial_clock;
      run_q <= (sck_q != cfg_mem_serial_clock) ? 8'h00 : run_q + 8'h01;
    end
  end

  // Decode kept apart from the design so a map slip shows up.
  function automatic logic mapped(input logic [11:0] a);
    case (a[11:2])
      10'h020, 10'h022, 10'h102, 10'h104, 10'h106, 10'h108, 10'h10A,
      10'h10C, 10'h10E, 10'h110, 10'h112, 10'h114, 10'h116, 10'h118,
      10'h200, 10'h201, 10'h202: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_mask_off;
    s_access ##0 pwrite && paddr == 12'h808 && pwdata[2:0] == 3'h0;
  endsequence

  a_ready_match: assert property (pready == (psel && penable))
    else $error("pready does not follow the access phase");
  a_unmapped_err: assert property (s_access ##0 !mapped(paddr)
    |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_read: assert property (s_access ##0 !pwrite && mapped(paddr)
    |-> !pslverr && prdata[31:16] == 16'h0000)
    else $error("mapped read flagged or upper half set");
  a_sck_in_frame: assert property (
    cfg_mem_serial_clock |-> cfg_mem_select)
    else $error("serial clock runs outside a frame");
  a_sck_half: assert property (
    $fell(cfg_mem_serial_clock) |-> run_q == 8'h7C)
    else $error("serial clock high phase not 125 cycles");
  a_frame_start: assert property (
    $rose(cfg_mem_select) |-> cfg_mem_serial_out && !cfg_mem_serial_clock)
    else $error("frame does not open with the start bit");
  a_dout_on_fall: assert property (
    cfg_mem_select && $past(cfg_mem_select) && $changed(cfg_mem_serial_out)
    |-> $fell(cfg_mem_serial_clock))
    else $error("serial data moved away from a clock fall");
  a_irq_masked: assert property (s_mask_off |-> ##2 !irq)
    else $error("interrupt stays up with all sources masked");
endmodule // ecl_loader_checker

bind ecl_loader ecl_loader_checker chk_u
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .cfg_mem_serial_in, .cfg_mem_select,
  .cfg_mem_serial_clock, .cfg_mem_serial_out, .irq
);
`default_nettype wire

// ===== ecl_mem_model.sv
// Behavioural three-wire memory for the loader's far side; big selects
// the long command of a large part, only 64 words are stored.
// Assumes the bench fills mem and rewinds next_addr before each restart.
`timescale 1ns/1ps
`default_nettype none
module ecl_mem_model
(
  // Memory pins.
  input  wire logic  cs,
  input  wire logic  sck,
  input  wire logic  di,
  output logic       do_o,
  // Observation.
  output logic       order_err,
  output logic [7:0] frames
);
  logic [15:0] mem [0:63];
  logic [10:0] cmd;
  logic [7:0]  next_addr;
  logic        big;
  int          bits;
  int          n;

  // Unselected, the data line floats high through its pull-up.
  initial
  begin
    do_o = 1'b1;
    order_err = 1'b0;
    frames = 8'h00;
    next_addr = 8'h00;
    big = 1'b0;
    bits = 0;
    n = 9;
  end

  // Takes the command on rising edges, then the zero dummy and the word
  // one edge each; a large part still floats high at the tenth edge.
  always @(posedge sck)
  begin
    if (cs)
    begin
      bits++;
      n = big ? 11 : 9;
      if (bits <= n)
        cmd = {cmd[9:0], di};
      if (bits == n)
      begin
        if (big ? (cmd !== {3'b110, next_addr})
                : (cmd[8:0] !== {3'b110, next_addr[5:0]}))
          order_err = 1'b1;
      end
      else if (bits == n + 1)
        do_o = 1'b0;
      else if (bits > n + 1 && bits < n + 18)
        do_o = mem[cmd[5:0]][n + 17 - bits];
    end
  end

  // A frame ends: the line is released and the next word is due.
  always @(negedge cs)
  begin
    if (bits > 0)
    begin
      bits = 0;
      do_o = 1'b1;
      frames++;
      next_addr++;
    end
  end
endmodule // ecl_mem_model
`default_nettype wire

// ===== ecl_loader_tb_top.sv
// Self-checking bench for the configuration loader.
// Assumes the loader, its bound checker and the memory model are built.
`timescale 1ns/1ps
`default_nettype none
module ecl_loader_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cfg_mem_serial_in, cfg_mem_select, cfg_mem_serial_clock;
  logic        cfg_mem_serial_out, irq, mem_do, present, order_err, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  frames;
  int          fails, cmp_count, cycles;

  // An absent memory leaves the sense line low.
  assign cfg_mem_serial_in = present ? mem_do : 1'b0;

  ecl_loader dut_u
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg_mem_serial_in, .cfg_mem_select,
    .cfg_mem_serial_clock, .cfg_mem_serial_out, .irq
  );
  ecl_mem_model mem_u
  (
    .cs(cfg_mem_select), .sck(cfg_mem_serial_clock),
    .di(cfg_mem_serial_out), .do_o(mem_do), .order_err, .frames
  );

  // Clock at 250 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Hang guard; three full loads need some 81k cycles.
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask

  // One APB transfer; a spare cycle after it keeps strobes apart.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // Polls status until initialisation reports done.
  task automatic wait_init();
    do
    begin
      repeat (100) @(posedge pclk);
      apb(1'b0, 12'h800, 32'h0);
    end
    while (rd[7] !== 1'b1);
  endtask

  task automatic restart();
    mem_u.next_addr = 8'h00;
    apb(1'b1, 12'h450, 32'h40);
    wait_init();
  endtask

  // No memory: defaults, no frames, and the interrupt path end to end.
  task automatic t_absent();
    wait_init();
    chk("frames", 32'h0, {24'h0, frames});
    rdc(12'h800, 32'h80, "status");
    rdc(12'h408, 32'h3, "rx_cfg");
    rdc(12'h804, 32'h4, "irq_stat");
    chk("irq", 32'h0, {31'h0, irq});
    // The interrupt follows the mask one edge late.
    apb(1'b1, 12'h808, 32'h4);
    @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h808, 32'h0);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h804, 32'h4);
    rdc(12'h804, 32'h0, "irq_stat");
    apb(1'b0, 12'hFFC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
  endtask

  // One group into rx_cfg; everything else stays at its default.
  task automatic t_load();
    mem_u.mem[0] = 16'hA104;
    mem_u.mem[1] = 16'h0102;
    mem_u.mem[2] = 16'h1234;
    mem_u.mem[3] = 16'h1200;
    present <= 1'b1;
    restart();
    chk("order", 32'h0, {31'h0, order_err});
    chk("frames", 32'h4, {24'h0, frames});
    chk("next", 32'h4, {24'h0, mem_u.next_addr});
    rdc(12'h408, 32'h1234, "rx_cfg");
    rdc(12'h410, 32'h5, "rx_ctl");
    rdc(12'h800, 32'h481, "status");
    rdc(12'h804, 32'h1, "irq_stat");
    apb(1'b1, 12'h804, 32'h7);
  endtask

  // Wrong checksum: the loaded value is rolled back.
  task automatic t_badsum();
    mem_u.mem[3] = 16'h1300;
    restart();
    rdc(12'h408, 32'h3, "rx_cfg");
    apb(1'b0, 12'h800, 32'h0);
    chk("status", 32'h80, rd & 32'h480);
    rdc(12'h804, 32'h2, "irq_stat");
  endtask

  // Large part: the probe sees the floating line, longer commands follow.
  task automatic t_big();
    mem_u.mem[3] = 16'h1200;
    mem_u.big = 1'b1;
    restart();
    chk("order", 32'h0, {31'h0, order_err});
    rdc(12'h408, 32'h1234, "rx_cfg");
    rdc(12'h800, 32'h483, "status");
  endtask

  // Suspend keeps only the base address; the waking write is dropped.
  task automatic t_suspend();
    present <= 1'b0;
    apb(1'b1, 12'h080, 32'h360);
    apb(1'b1, 12'h410, 32'h77);
    apb(1'b1, 12'h450, 32'h100);
    apb(1'b1, 12'h410, 32'h55);
    wait_init();
    rdc(12'h080, 32'h360, "io_base");
    rdc(12'h410, 32'h5, "rx_ctl");
  endtask

  // Main sequence.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    present = 1'b0;
    fails = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_absent();
    t_load();
    t_badsum();
    t_big();
    t_suspend();
    stop_test();
  end
endmodule // ecl_loader_tb_top
`default_nettype wire
